// ---- phy_port_end.sv ----
`timescale 1ns/100ps
module phy_port_end
  import mii_port_pkg::*;
#(
  parameter logic [3:0] STRAP_WAIT = STRAP_HOLD
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // pins toward the mac
  mii_link_if.phy         LINK,
  // configuration and captured straps
  input  wire logic       SYMBOL_MODE,
  output logic            RMII_ACTIVE,
  output logic [2:0]      OP_MODE,
  output logic [2:0]      MGMT_ADDR,
  output logic            SPEED_100,
  // transmit toward the line coder
  output logic            LINE_TX_STB,
  output logic            LINE_TX_ACTIVE,
  output logic [4:0]      LINE_TX_SYM,
  // receive from the line decoder
  input  wire logic       LINE_RX_STB,
  input  wire logic [3:0] LINE_RX_NIB,
  input  wire logic       LINE_RX_ERR,
  input  wire logic       LINE_RX_SYM4,
  input  wire logic       LINE_RX_CARRIER,
  input  wire logic       LINE_COL,
  output logic            LINE_RX_BUSY,
  // interrupt request from status logic
  input  wire logic       IRQ_REQ
);

  // ==========================================================
  // synchronizers: a level counts once stages two and three agree
  localparam int NSYNC = NSHARED + 7;
  wire  [NSYNC-1:0] pin_raw = {LINK.sh_pin, LINK.ref_clk, LINK.tx_er,
                               LINK.tx_en, LINK.txd};
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, st_r;
  wire  [NSYNC-1:0] st_nxt = (s2_r & s3_r) | (st_r & (s2_r ^ s3_r));
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      st_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_nxt;
    end
  end
  wire [3:0]         txd_s   = st_r[3:0];
  wire               tx_en_s = st_r[4];
  wire               tx_er_s = st_r[5];
  wire               ref_s   = st_r[6];
  wire [NSHARED-1:0] sh_s    = st_r[NSYNC-1:7];

  // ==========================================================
  // strap capture after reset release
  // shared pins stay undriven until the capture so the pulls win
  strap_state_t state_r, state_nxt;
  logic [3:0]   wait_r;
  logic         rmii_r, speed_r;
  logic [2:0]   mode_r, addr_r;
  wire          wait_done = (wait_r == STRAP_WAIT);
  wire          run       = (state_r == ST_RUN);
  wire          capture   = (state_r == ST_STRAP) & wait_done;
  wire [2:0]    mode_pin  = {sh_s[PIN_CRDV], sh_s[PIN_RXD1], sh_s[PIN_RXD0]};
  wire [2:0]    addr_pin  = {sh_s[PIN_RXD3], sh_s[PIN_RXCK], sh_s[PIN_RXER]};
  wire          spd_pin   = (mode_pin != MODE_10HD) & (mode_pin != MODE_10FD);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STRAP: if (wait_done) state_nxt = ST_RUN;
      ST_RUN:   state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_STRAP;
      wait_r  <= '0;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_done ? wait_r : wait_r + 4'h1;
    end
  end

  // captured values hold until the next reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rmii_r  <= SEL_MII;
      mode_r  <= '0;
      addr_r  <= '0;
      speed_r <= 1'b0;
    end else if (capture) begin                      // [R14]
      rmii_r  <= (sh_s[PIN_RXD2] == SEL_RMII);       // [R10]
      mode_r  <= mode_pin;                           // [R11]
      addr_r  <= addr_pin;                           // [R12]
      speed_r <= spd_pin;                            // [R11]
    end
  end

  // ==========================================================
  // mii clock divider: one counter feeds tx and rx clocks
  logic [DIVW-1:0] div_r;
  logic            clk_r;
  wire  [DIVW-1:0] period   = speed_r ? DIV_MII100 : DIV_MII10;
  wire             div_wrap = (div_r == period - DIVW'(1));
  wire             mii_rise = run & ~rmii_r & (div_r == '0);
  wire             mii_fall = run & ~rmii_r & (div_r == (period >> 1));
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      div_r <= '0;
      clk_r <= 1'b0;
    end else begin
      div_r <= (!run || div_wrap) ? '0 : div_r + DIVW'(1);
      if (mii_rise)
        clk_r <= 1'b1;                               // [R08] [R15]
      else if (mii_fall)
        clk_r <= 1'b0;
    end
  end

  // ==========================================================
  // rmii slots on reference edges; 10M uses every tenth edge
  logic       ref_prev_r;
  logic [3:0] rep_r;
  wire        ref_rise  = run & rmii_r & ref_s & ~ref_prev_r;  // [R18]
  wire        rep_wrap  = (rep_r == RMII10_REPEAT - 4'h1);
  wire        rmii_slot = ref_rise & (speed_r | (rep_r == 4'h0));
  wire        slot_tx   = mii_rise | rmii_slot;
  wire        slot_rx   = mii_fall | rmii_slot;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ref_prev_r <= 1'b0;
      rep_r      <= '0;
    end else begin
      ref_prev_r <= ref_s;
      if (ref_rise)
        rep_r <= rep_wrap ? 4'h0 : rep_r + 4'h1;
    end
  end

  // ==========================================================
  // transmit: sample pins, pair rmii dibits, encode
  logic       tx_half_r;
  logic [1:0] tx_lo_r;
  logic       ltx_stb_r, ltx_act_r;
  logic [4:0] ltx_sym_r;
  // upper lines never read in rmii, so a floating pair is harmless
  wire  [3:0] tx_nib  = rmii_r ? {txd_s[1:0], tx_lo_r} : txd_s;  // [R04]
  wire        use_sym = ~rmii_r & speed_r & SYMBOL_MODE;
  wire        use_err = ~rmii_r & speed_r & tx_er_s;             // [R06]
  wire  [4:0] tx_sym  = ~speed_r ? {1'b0, tx_nib}
                      : use_sym  ? {tx_er_s, txd_s}              // [R07]
                      : use_err  ? SYM_TX_ERR                    // [R05]
                      : enc4b5b(tx_nib);
  wire        tx_word = slot_tx & tx_en_s & (~rmii_r | tx_half_r); // [R03]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_half_r <= 1'b0;
      tx_lo_r   <= '0;
      ltx_act_r <= 1'b0;
    end else if (slot_tx) begin
      tx_half_r <= rmii_r & tx_en_s & ~tx_half_r;
      tx_lo_r   <= txd_s[1:0];
      ltx_act_r <= tx_en_s;
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ltx_stb_r <= 1'b0;
      ltx_sym_r <= '0;
    end else begin
      ltx_stb_r <= tx_word;
      if (tx_word)
        ltx_sym_r <= tx_sym;
    end
  end

  // ==========================================================
  // receive: one-nibble hold register from the line decoder
  logic       hold_vld_r, hold_err_r, hold_sym4_r;
  logic [3:0] hold_nib_r;
  wire        take = slot_rx & hold_vld_r & (~rmii_r | ~rx_half_r);
  wire        load = LINE_RX_STB & (~hold_vld_r | take);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_vld_r  <= 1'b0;
      hold_nib_r  <= '0;
      hold_err_r  <= 1'b0;
      hold_sym4_r <= 1'b0;
    end else begin
      hold_vld_r <= load | (hold_vld_r & ~take);
      if (load) begin
        hold_nib_r  <= LINE_RX_NIB;
        hold_err_r  <= LINE_RX_ERR;
        hold_sym4_r <= LINE_RX_SYM4;
      end
    end
  end

  // rmii 10M keeps dibits at zero through the preamble
  logic       rx_half_r, cur_gate_r, sfd_seen_r;
  logic [1:0] cur_hi_r;
  wire        sfd_now   = ~speed_r & (hold_nib_r == NIB_SFD_HI);
  wire        gate_open = speed_r | sfd_seen_r | sfd_now;       // [R16]
  wire  [1:0] lo_dibit  = gate_open ? hold_nib_r[1:0] : 2'b00;
  wire  [1:0] hi_dibit  = cur_gate_r ? cur_hi_r : 2'b00;
  // rmii carries data on the two low lines; the upper two are driven low
  wire  [3:0] rxd_nxt   = ~rmii_r    ? hold_nib_r
                        : rx_half_r  ? {2'b00, hi_dibit}        // [R09]
                        : hold_vld_r ? {2'b00, lo_dibit}
                        : 4'h0;
  wire        rxer_nxt  = hold_vld_r & ~(rmii_r & rx_half_r) &
                          ((~rmii_r & SYMBOL_MODE) ? hold_sym4_r
                                                   : hold_err_r); // [R17]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_half_r  <= 1'b0;
      cur_gate_r <= 1'b0;
      cur_hi_r   <= '0;
    end else if (slot_rx & rmii_r) begin
      rx_half_r  <= ~rx_half_r & hold_vld_r;
      cur_gate_r <= gate_open;
      cur_hi_r   <= hold_nib_r[3:2];
    end
  end
  // the seen flag set wins over the end-of-carrier clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      sfd_seen_r <= 1'b0;
    else
      sfd_seen_r <= (take & sfd_now) | (sfd_seen_r & LINE_RX_CARRIER);
  end

  // ==========================================================
  // receive pin registers
  logic [3:0]         rxd_r;
  logic               rx_er_r, dv_r, crs_r, pin6_r, irq_oe_r;
  logic [NSHARED-1:0] oe_r;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rxd_r   <= '0;
      rx_er_r <= 1'b0;
      dv_r    <= 1'b0;
    end else if (slot_rx) begin
      rxd_r   <= rxd_nxt;                              // [R09]
      rx_er_r <= rxer_nxt;                             // [R17]
      dv_r    <= ~rmii_r & hold_vld_r;
    end
  end
  // carrier, collision, pin enables and interrupt
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      crs_r    <= 1'b0;
      pin6_r   <= 1'b0;
      oe_r     <= '0;
      irq_oe_r <= 1'b0;
    end else begin
      crs_r    <= run & ~rmii_r & LINE_RX_CARRIER;
      pin6_r   <= run & (rmii_r ? LINE_RX_CARRIER : LINE_COL); // [R16]
      oe_r     <= run ? '1 : '0;                             // [R14]
      irq_oe_r <= run & IRQ_REQ;                             // [R13]
    end
  end

  // ==========================================================
  // pin and user outputs
  assign LINK.tx_clk  = clk_r;                               // [R08]
  assign LINK.rx_dv   = dv_r;
  assign LINK.crs     = crs_r;
  assign LINK.sh_o    = {pin6_r, clk_r, rx_er_r, rxd_r};     // [R15]
  assign LINK.sh_oe   = oe_r;
  assign LINK.irq_o   = 1'b0;                                // [R13]
  assign LINK.irq_oe  = irq_oe_r;
  assign RMII_ACTIVE  = rmii_r;
  assign OP_MODE      = mode_r;
  assign MGMT_ADDR    = addr_r;
  assign SPEED_100    = speed_r;
  assign LINE_TX_STB  = ltx_stb_r;
  assign LINE_TX_ACTIVE = ltx_act_r;
  assign LINE_TX_SYM  = ltx_sym_r;
  assign LINE_RX_BUSY = hold_vld_r;

endmodule

// ---- mii_port_pkg.sv ----
// Summary of operation
// R01: MAC drives data on TXD[1:0] always.
// R02: MAC grounds TXD[3:2] in RMII.
// R03: TX_EN marks valid data; four lines MII.
// R04: RMII takes only TXD[1:0] under TX_EN.
// R05: TX_ER at 100M MII sends /H/.
// R06: TX_ER ignored at 10 Mb/s.
// R07: symbol mode: TX_ER is symbol MSB.
// R08: MII TX clock 25 or 2.5 MHz.
// R09: RX data four lines MII, two RMII.
// R10: select strap low MII, high RMII.
// R11: three mode straps set default mode.
// R12: three address straps form management address.
// R13: interrupt pulled low, released otherwise.
// R14: straps captured at reset, pins revert.
// R15: MII RX clock 25 or 2.5 MHz.
// R16: RMII 10M dibits low until SFD.
// R17: RX error flags error in frame.
// R18: RMII dibits move on reference clock.
package mii_port_pkg;

  // ==========================================================
  // time base
  localparam int CLK_KHZ    = 250000;
  localparam int MII100_KHZ = 25000;
  localparam int MII10_KHZ  = 2500;
  localparam int REF_KHZ    = 50000;
  localparam int DIVW       = 7;
  localparam logic [DIVW-1:0] DIV_MII100   = DIVW'(CLK_KHZ / MII100_KHZ);
  localparam logic [DIVW-1:0] DIV_MII10    = DIVW'(CLK_KHZ / MII10_KHZ);
  localparam logic [DIVW-1:0] DIV_REF      = DIVW'(CLK_KHZ / REF_KHZ);
  localparam logic [DIVW-1:0] REF_HIGH     = DIVW'(CLK_KHZ / REF_KHZ / 2);
  localparam logic [DIVW-1:0] REF_TX_PHASE = 7'h02;
  localparam logic [3:0]      RMII10_REPEAT = 4'ha;
  localparam logic [3:0]      STRAP_HOLD    = 4'h8;

  // ==========================================================
  // shared pins: normal function / strap function
  localparam int NSHARED  = 7;
  localparam int PIN_RXD0 = 0;  // mode bit 0
  localparam int PIN_RXD1 = 1;  // mode bit 1
  localparam int PIN_RXD2 = 2;  // interface select
  localparam int PIN_RXD3 = 3;  // address bit 2
  localparam int PIN_RXER = 4;  // address bit 0
  localparam int PIN_RXCK = 5;  // address bit 1
  localparam int PIN_CRDV = 6;  // mode bit 2

  // ==========================================================
  // encodings
  localparam logic       SEL_MII    = 1'b0;
  localparam logic       SEL_RMII   = 1'b1;
  localparam logic [2:0] MODE_10HD  = 3'h0;
  localparam logic [2:0] MODE_10FD  = 3'h1;
  localparam logic [4:0] SYM_TX_ERR = 5'h04;
  localparam logic [3:0] NIB_SFD_HI = 4'hd;

  typedef enum logic {ST_STRAP, ST_RUN} strap_state_t;

  // 4b/5b data code-groups
  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h1e;
    unique case (n)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      4'hf: s = 5'h1d;
    endcase
    return s;
  endfunction

endpackage

// ---- mii_link_if.sv ----
`timescale 1ns/100ps
interface mii_link_if;
  import mii_port_pkg::*;

  // ==========================================================
  // transmit pins and clocks
  logic [3:0]         txd;
  logic               tx_en;
  logic               tx_er;
  logic               tx_clk;
  logic               ref_clk;
  // ==========================================================
  // receive pins, shared ones resolved against strap pulls
  logic               rx_dv;
  logic               crs;
  logic [NSHARED-1:0] sh_o;
  logic [NSHARED-1:0] sh_oe;
  logic [NSHARED-1:0] sh_pull;
  logic [NSHARED-1:0] sh_pin;
  // open-drain interrupt with pull-up
  logic               irq_o;
  logic               irq_oe;
  logic               irq_pin;

  assign sh_pin  = (sh_oe & sh_o) | (~sh_oe & sh_pull);
  assign irq_pin = ~irq_oe | irq_o;

  modport phy (input txd, tx_en, tx_er, ref_clk, sh_pin,
               output tx_clk, rx_dv, crs, sh_o, sh_oe, irq_o, irq_oe);
  modport mac (output txd, tx_en, tx_er, ref_clk, sh_pull,
               input tx_clk, rx_dv, crs, sh_pin, irq_pin);
endinterface

// ---- mac_port_end.sv ----
`timescale 1ns/100ps
module mac_port_end
  import mii_port_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // pins toward the transceiver
  mii_link_if.mac         LINK,
  // board straps and mode
  input  wire logic       RMII_MODE,
  input  wire logic       SPEED_100,
  input  wire logic       SYMBOL_MODE,
  input  wire logic [2:0] STRAP_MODE,
  input  wire logic [2:0] STRAP_ADDR,
  // transmit stream
  input  wire logic       TX_VALID,
  input  wire logic [3:0] TX_DATA,
  input  wire logic       TX_ERR,
  input  wire logic       TX_SYM4,
  output logic            TX_TAKEN,
  // receive stream
  output logic            RX_STB,
  output logic [3:0]      RX_DATA,
  output logic            RX_ERR,
  output logic            RX_DV,
  output logic            CRS,
  output logic            COL,
  output logic            IRQ
);

  // ==========================================================
  // synchronizers for transceiver-driven pins
  localparam int NSYNC = NSHARED + 4;
  // irq taken inverted so the reset value matches the idle pin
  wire  [NSYNC-1:0] pin_raw = {~LINK.irq_pin, LINK.sh_pin, LINK.crs,
                               LINK.rx_dv, LINK.tx_clk};
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, st_r;
  wire  [NSYNC-1:0] st_nxt = (s2_r & s3_r) | (st_r & (s2_r ^ s3_r));
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      st_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_nxt;
    end
  end
  wire               txck_s = st_r[0];
  wire               rxdv_s = st_r[1];
  wire               crs_s  = st_r[2];
  wire [NSHARED-1:0] sh_s   = st_r[NSYNC-2:3];
  wire               irq_s  = st_r[NSYNC-1];

  // ==========================================================
  // reference clock divider; 10M repeats each dibit
  logic [DIVW-1:0] ref_cnt_r;
  logic [3:0]      rep_r;
  logic            ref_r;
  logic            txck_prev_r;
  logic            rxck_prev_r;
  wire             ref_wrap = (ref_cnt_r == DIV_REF - DIVW'(1));
  wire [DIVW-1:0]  ref_nxt  = ref_wrap ? '0 : ref_cnt_r + DIVW'(1);
  wire             rep_go   = SPEED_100 | (rep_r == 4'h0);
  wire             rm_tx    = RMII_MODE & rep_go & (ref_cnt_r == REF_TX_PHASE);
  wire             rm_rx    = RMII_MODE & rep_go & (ref_cnt_r == '0);
  wire             mii_tx   = ~RMII_MODE & txck_s & ~txck_prev_r;
  wire             mii_rx   = ~RMII_MODE & sh_s[PIN_RXCK] & ~rxck_prev_r;
  wire             rep_wrap = (rep_r == RMII10_REPEAT - 4'h1);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ref_cnt_r   <= DIV_REF - DIVW'(1);  // no runt first pulse
      rep_r       <= '0;
      ref_r       <= 1'b0;
      txck_prev_r <= 1'b0;
      rxck_prev_r <= 1'b0;
    end else begin
      ref_cnt_r   <= ref_nxt;
      if (ref_wrap)
        rep_r <= rep_wrap ? 4'h0 : rep_r + 4'h1;
      ref_r       <= RMII_MODE & (ref_nxt < REF_HIGH);  // [R18]
      txck_prev_r <= txck_s;
      rxck_prev_r <= sh_s[PIN_RXCK];
    end
  end

  // ==========================================================
  // transmit: nibbles in MII, low dibit first in RMII
  logic [3:0] txd_r;
  logic       tx_en_r, tx_er_r, taken_r, tx_half_r;
  logic [1:0] tx_hi_r;
  wire        tx_slot  = mii_tx | rm_tx;
  wire        tx_first = tx_slot & TX_VALID & ~(RMII_MODE & tx_half_r);
  wire [3:0]  txd_nxt  = ~RMII_MODE ? TX_DATA                    // [R03]
                       : tx_half_r ? {2'b00, tx_hi_r}            // [R02]
                       : {2'b00, TX_DATA[1:0]};                  // [R01]
  wire        tx_er_nxt = ~RMII_MODE & (SYMBOL_MODE ? TX_SYM4 : TX_ERR); // [R07]
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      txd_r     <= '0;
      tx_en_r   <= 1'b0;
      tx_er_r   <= 1'b0;
      tx_half_r <= 1'b0;
      tx_hi_r   <= '0;
    end else if (tx_slot) begin
      tx_en_r   <= TX_VALID | (RMII_MODE & tx_half_r);
      txd_r     <= (TX_VALID | tx_half_r) ? txd_nxt : 4'h0;
      tx_er_r   <= TX_VALID & tx_er_nxt;
      tx_half_r <= RMII_MODE & ~tx_half_r & TX_VALID;
      tx_hi_r   <= TX_DATA[3:2];
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      taken_r <= 1'b0;
    else
      taken_r <= tx_first;
  end

  // ==========================================================
  // receive: align RMII pairs on first non-zero dibit
  logic       rx_stb_r, rx_err_r, rx_half_r, rx_align_r;
  logic       rx_dv_r, crs_r, col_r, irq_r;
  logic [1:0] rx_lo_r;
  logic [3:0] rx_data_r;
  wire  [1:0] dibit    = sh_s[PIN_RXD1:PIN_RXD0];
  wire        crsdv_s  = sh_s[PIN_CRDV];
  wire        rm_live  = rm_rx & crsdv_s & (rx_align_r | dibit != 2'b00);
  wire        rm_pair  = rm_live & rx_half_r;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_stb_r   <= 1'b0;
      rx_err_r   <= 1'b0;
      rx_half_r  <= 1'b0;
      rx_align_r <= 1'b0;
      rx_lo_r    <= '0;
      rx_data_r  <= '0;
    end else begin
      rx_stb_r <= (mii_rx & rxdv_s) | rm_pair;
      if (mii_rx) begin
        rx_data_r <= sh_s[PIN_RXD3:PIN_RXD0];
        rx_err_r  <= sh_s[PIN_RXER];
      end else if (rm_pair) begin
        rx_data_r <= {dibit, rx_lo_r};
        rx_err_r  <= sh_s[PIN_RXER];
      end
      if (rm_rx & ~crsdv_s) begin
        rx_half_r  <= 1'b0;
        rx_align_r <= 1'b0;
      end else if (rm_live) begin
        rx_half_r  <= ~rx_half_r;
        rx_align_r <= 1'b1;
        rx_lo_r    <= dibit;
      end
    end
  end
  // carrier, collision and interrupt levels
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_dv_r <= 1'b0;
      crs_r   <= 1'b0;
      col_r   <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      rx_dv_r <= RMII_MODE ? crsdv_s : rxdv_s;
      crs_r   <= RMII_MODE ? crsdv_s : crs_s;
      col_r   <= ~RMII_MODE & crsdv_s;
      irq_r   <= irq_s;
    end
  end

  // board strap resistors, held from reset on
  logic [NSHARED-1:0] pull_r;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      pull_r <= '0;
    else
      pull_r <= {STRAP_MODE[2], STRAP_ADDR[1], STRAP_ADDR[0],
                 STRAP_ADDR[2], RMII_MODE, STRAP_MODE[1:0]};
  end

  assign LINK.txd     = txd_r;
  assign LINK.tx_en   = tx_en_r;
  assign LINK.tx_er   = tx_er_r;
  assign LINK.ref_clk = ref_r;
  assign LINK.sh_pull = pull_r;
  assign TX_TAKEN     = taken_r;
  assign RX_STB       = rx_stb_r;
  assign RX_DATA      = rx_data_r;
  assign RX_ERR       = rx_err_r;
  assign RX_DV        = rx_dv_r;
  assign CRS          = crs_r;
  assign COL          = col_r;
  assign IRQ          = irq_r;

endmodule

// ---- link_checker.sv ----
`timescale 1ns/100ps
module link_checker
  import mii_port_pkg::*;
(
  // clock and reset
  input wire logic               CLK,
  input wire logic               NRST,
  // link pins
  input wire logic [3:0]         txd,
  input wire logic               tx_er,
  input wire logic               tx_clk,
  input wire logic               ref_clk,
  input wire logic               rx_dv,
  input wire logic               crs,
  input wire logic [NSHARED-1:0] sh_oe,
  input wire logic [NSHARED-1:0] sh_pull,
  input wire logic               irq_oe,
  input wire logic               irq_pin
);
  // ==========================================================
  // cycles since release, saturating so it never wraps
  logic [3:0] up_r;
  wire        rmii = sh_pull[PIN_RXD2];
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST) up_r <= 4'h0;
    else if (up_r != 4'hf) up_r <= up_r + 4'h1;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================
  // pin usage per interface type
  a_rmii_upper_low: assert property (rmii |-> txd[3:2] == 2'h0)
    else $error("upper tx lines driven in reduced mode");
  a_rmii_no_txer: assert property (rmii |-> !tx_er)
    else $error("tx error driven in reduced mode");
  a_rmii_no_txclk: assert property (rmii |-> !tx_clk)
    else $error("tx clock runs in reduced mode");
  a_rmii_no_rxdv: assert property (rmii |-> !rx_dv && !crs)
    else $error("mii receive flags in reduced mode");
  a_mii_no_ref: assert property (!rmii |-> !ref_clk)
    else $error("reference clock runs in mii mode");
  // clock shapes: ref high 2 low 3, tx period at least 9
  a_ref_shape: assert property ($rose(ref_clk) |-> ##1 ref_clk
    ##1 !ref_clk [*3] ##1 ref_clk) else $error("reference clock shape");
  a_txclk_period: assert property ($rose(tx_clk) |=>
    !$rose(tx_clk) [*8]) else $error("tx clock too fast");
  // straps must see pins released, then pins return to output
  a_strap_quiet: assert property (up_r < 4'h6 |-> sh_oe == '0)
    else $error("shared pins driven during strap sampling");
  a_strap_done: assert property (up_r == 4'hf |-> &sh_oe)
    else $error("shared pins not driven after straps");
  a_irq_low: assert property (irq_oe |-> !irq_pin)
    else $error("interrupt pin not pulled low");
  c_txclk: cover property ($rose(tx_clk));
  c_ref: cover property ($rose(ref_clk));
  c_irq: cover property ($rose(irq_oe));
endmodule

// ---- tb_mii_rmii_phy_host_port.sv ----
`timescale 1ns/100ps
module tb_mii_rmii_phy_host_port
  import mii_port_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic       clk = 1'b0;
  logic       nrst, rmii, spd, sym, tx_v, tx_err, tx_s4, irq_req;
  logic       lrx_stb, lrx_err, lrx_car, tx_tk, rx_stb, rx_err;
  logic       rx_dv, crs, col, irq, r_act, p_spd, ltx_stb, ltx_act, busy;
  logic [2:0] smode, saddr, op_mode, maddr;
  logic [3:0] tx_d, lrx_nib, rx_d;
  logic [4:0] ltx_sym;
  int         miscompares = 0, compares = 0, cyc = 0, n;
  always #2 clk = ~clk;
  mii_link_if link();
  mac_port_end mac_port_end_i (
    .CLK(clk), .NRST(nrst), .LINK(link), .RMII_MODE(rmii),
    .SPEED_100(spd), .SYMBOL_MODE(sym), .STRAP_MODE(smode),
    .STRAP_ADDR(saddr), .TX_VALID(tx_v), .TX_DATA(tx_d), .TX_ERR(tx_err),
    .TX_SYM4(tx_s4), .TX_TAKEN(tx_tk), .RX_STB(rx_stb), .RX_DATA(rx_d),
    .RX_ERR(rx_err), .RX_DV(rx_dv), .CRS(crs), .COL(col), .IRQ(irq));
  phy_port_end phy_port_end_i (
    .CLK(clk), .NRST(nrst), .LINK(link), .SYMBOL_MODE(sym),
    .RMII_ACTIVE(r_act), .OP_MODE(op_mode), .MGMT_ADDR(maddr),
    .SPEED_100(p_spd), .LINE_TX_STB(ltx_stb), .LINE_TX_ACTIVE(ltx_act),
    .LINE_TX_SYM(ltx_sym), .LINE_RX_STB(lrx_stb), .LINE_RX_NIB(lrx_nib),
    .LINE_RX_ERR(lrx_err), .LINE_RX_SYM4(1'b0), .LINE_RX_CARRIER(lrx_car),
    .LINE_COL(1'b0), .LINE_RX_BUSY(busy), .IRQ_REQ(irq_req));
  link_checker link_checker_i (
    .CLK(clk), .NRST(nrst), .txd(link.txd), .tx_er(link.tx_er),
    .tx_clk(link.tx_clk), .ref_clk(link.ref_clk), .rx_dv(link.rx_dv),
    .crs(link.crs), .sh_oe(link.sh_oe), .sh_pull(link.sh_pull),
    .irq_oe(link.irq_oe), .irq_pin(link.irq_pin));
  // ==========================================================
  // compare, verdict and hang guard
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================
  // reset with new straps; straps need a reset to be taken
  task automatic cfg(logic r, logic [2:0] m, logic [2:0] a);
    nrst = 1'b0;
    rmii = r;
    smode = m;
    saddr = a;
    spd = (m > 3'h1);
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (20) @(posedge clk);
    #1 chk("straps", {r, m, a, spd}, {r_act, op_mode, maddr, p_spd});
  endtask
  // one nibble out; handshake waits are bounded
  task automatic tx(logic [3:0] d, logic e, logic s, logic [4:0] exp);
    tx_d = d;
    tx_err = e;
    tx_s4 = s;
    tx_v = 1'b1;
    for (n = 0; n < 400 && tx_tk !== 1'b1; n++) @(posedge clk) #1;
    tx_v = 1'b0;
    for (n = 0; n < 1200 && !(ltx_stb && ltx_act); n++) @(posedge clk) #1;
    chk("tx symbol", {3'h0, exp}, {3'h0, ltx_sym});
  endtask
  // line nibble into the hold register, carrier left up
  task automatic put(logic [3:0] d, logic e);
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk) #1;
    lrx_nib = d;
    lrx_err = e;
    lrx_stb = 1'b1;
    lrx_car = 1'b1;
    @(posedge clk) #1 lrx_stb = 1'b0;
  endtask
  task automatic get(logic [4:0] exp);
    for (n = 0; n < 1200 && rx_stb !== 1'b1; n++) @(posedge clk) #1;
    chk("rx nibble", {3'h0, exp}, {3'h0, rx_err, rx_d});
    chk("rx flags", 8'h06, {5'h0, rx_dv, crs, col});
    lrx_car = 1'b0;
  endtask
  // ==========================================================
  // main sequence: mii 100, mii 10, rmii 100, rmii 10
  initial begin
    {nrst, rmii, spd, sym, tx_v, tx_err, tx_s4, irq_req} = '0;
    {lrx_stb, lrx_err, lrx_car, smode, saddr, tx_d, lrx_nib} = '0;
    cfg(1'b0, 3'h7, 3'h5);
    tx(4'h0, 1'b0, 1'b0, 5'h1e);
    tx(4'h5, 1'b1, 1'b0, SYM_TX_ERR);
    sym = 1'b1;
    tx(4'h3, 1'b0, 1'b1, 5'h13);
    sym = 1'b0;
    put(4'ha, 1'b1);
    get(5'h1a);
    irq_req = 1'b1;
    repeat (12) @(posedge clk);
    #1 chk("irq on", 8'h01, {6'h0, link.irq_pin, irq});
    irq_req = 1'b0;
    repeat (12) @(posedge clk);
    #1 chk("irq off", 8'h02, {6'h0, link.irq_pin, irq});
    $display("test mii fast done");
    cfg(1'b0, 3'h0, 3'h2);
    tx(4'h6, 1'b1, 1'b0, 5'h06);
    $display("test mii slow done");
    cfg(1'b1, 3'h3, 3'h1);
    tx(4'h0, 1'b0, 1'b0, 5'h1e);
    put(4'h9, 1'b0);
    get(5'h09);
    $display("test rmii fast done");
    cfg(1'b1, 3'h1, 3'h6);
    put(4'h5, 1'b0);
    put(4'hd, 1'b0);
    get(5'h0d);
    $display("test rmii slow done");
    test_done();
  end
endmodule
